// ---- core/craf_pkg.sv ----
// Constants and types for the CAN receive acceptance filter block
//
// Overview of operation
// R01 - A filter matches only if each compared extended identifier bit 15..0 equals the filter's stored bit.
// R02 - Each filter's two-bit selector picks mask 0 (00), mask 1 (01) or mask 2 (10); code 11 is reserved.
// R03 - The low selector register holds filters 0..7, filter 0 at bits 1-0 up to filter 7 at bits 15-14.
// R04 - The high selector register holds filters 8..15, filter 8 at bits 1-0 up to filter 15 at bits 15-14.
// R05 - Three masks exist; a one in a mask's standard identifier field includes that bit, a zero ignores it.
// R06 - Mask extended identifier bits 17..16 and 15..0 include (one) or ignore (zero) the matching bit.
// R07 - With the mask's type mode bit set, only frames whose format agrees with the filter's extended enable pass.
// R08 - With the type mode bit clear, either format passes when the compared standard or standard+extended bits match.
// R09 - A buffer's occupied flag is set when the block fills it; buffers 0..15 sit at bits 15..0 of the low register; the code puts buffer n at bit n.
// R10 - Software clears occupied and overrun flags only by writing zero; writing one leaves them; all reset to zero.
// R11 - Occupied flags for buffers 16..31 sit in the high register, buffer 16 at bit 0 and buffer 31 at bit 15.
// R12 - All selector fields reset to zero; filter and mask identifier values are left undefined by reset.
// R13 - A buffer's overrun flag is set when a received frame is aimed at that buffer while it is already occupied.
// R14 - A hit needs every identifier bit included by the selected mask to match plus the type condition; in type mode clear the code needs standard bits only.
package craf_pkg;

  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int NUM_BUFS = 32;

  // Register byte offsets
  localparam logic [11:0] FLT_EID_BASE = 12'h000;
  localparam logic [11:0] FLT_SID_BASE = 12'h040;
  localparam logic [11:0] MSK_SID_BASE = 12'h080;
  localparam logic [11:0] MSK_EID_BASE = 12'h090;
  localparam logic [11:0] SEL_LOW_OFS = 12'h0a0;
  localparam logic [11:0] SEL_HIGH_OFS = 12'h0a4;
  localparam logic [11:0] FULL_LOW_OFS = 12'h0a8;
  localparam logic [11:0] FULL_HIGH_OFS = 12'h0ac;
  localparam logic [11:0] OVF_LOW_OFS = 12'h0b0;
  localparam logic [11:0] OVF_HIGH_OFS = 12'h0b4;
  localparam logic [11:0] INT_STAT_OFS = 12'h0b8;
  localparam logic [11:0] INT_CLR_OFS = 12'h0bc;
  localparam logic [11:0] INT_EN_OFS = 12'h0c0;

  // Standard identifier register layout (filter and mask share it)
  localparam int SID_LSB = 5;
  localparam int TYPE_BIT = 3;
  localparam int EIDHI_LSB = 0;
  localparam logic [15:0] SID_REG_WMASK = 16'hffeb;

  // Reset values
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [1:0] INT_RESET = 2'h0;

  // Interrupt status bits
  localparam int INT_ACCEPT = 0;
  localparam int INT_OVERRUN = 1;

  // Mask-source selector codes
  typedef enum logic [1:0] {
    SEL_MASK0 = 2'h0,
    SEL_MASK1 = 2'h1,
    SEL_MASK2 = 2'h2,
    SEL_RSVD = 2'h3
  } craf_sel_e;

  // Frame identifier delivered by the protocol engine
  typedef struct packed {
    logic valid;
    logic ext;
    logic [10:0] std_ident_bits;
    logic [17:0] ext_ident_bits;
    logic [4:0] bufIdx;
  } craf_frame_s;

  // Store request to the message-buffer RAM
  typedef struct packed {
    logic valid;
    logic [4:0] bufIdx;
    logic [4:0] filterNum;
  } craf_store_s;

endpackage

// ---- core/craf_acceptance_filter.sv ----
// Acceptance filter, receive buffer flags and APB register file
`timescale 1ns/1ps
module craf_acceptance_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire craf_pkg::craf_frame_s rxFrame,
  output craf_pkg::craf_store_s store,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] fltEid [craf_pkg::NUM_FILTERS];
  logic [15:0] fltSid [craf_pkg::NUM_FILTERS];
  logic [15:0] mskSid [craf_pkg::NUM_MASKS];
  logic [15:0] mskEid [craf_pkg::NUM_MASKS];
  logic [15:0] selLow;
  logic [15:0] selHigh;
  logic [31:0] fullFlag;
  logic [31:0] ovfFlag;
  logic [1:0] intStat;
  logic [1:0] intEn;

  logic apbDone;
  logic apbWr;
  logic [31:0] rdata;
  logic rdErr;
  logic [15:0] wd;
  logic [3:0] fIdx;
  logic [1:0] mIdx;
  logic [15:0] hitVec;
  logic anyHit;
  logic [4:0] hitNum;
  logic [31:0] setFull;
  logic [31:0] setOvf;
  logic [31:0] next_fullFlag;
  logic [31:0] next_ovfFlag;
  logic [1:0] next_intStat;

  assign apbDone = psel && penable && pready;
  assign apbWr = apbDone && pwrite;
  assign wd = pwdata[15:0];
  assign fIdx = paddr[5:2];
  assign mIdx = paddr[3:2];

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state so the read mux can be registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rdata : 32'h0;
      pslverr <= psel && penable && !pready && rdErr;
    end
  end

  // Read mux and address decode; unmapped addresses answer with an error
  always_comb begin
    rdata = 32'h0000_0000;
    rdErr = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rdErr = 1'b1;
    end else if (paddr[11:6] == craf_pkg::FLT_EID_BASE[11:6]) begin
      rdata[15:0] = fltEid[fIdx];
    end else if (paddr[11:6] == craf_pkg::FLT_SID_BASE[11:6]) begin
      rdata[15:0] = fltSid[fIdx] & craf_pkg::SID_REG_WMASK;
    end else if (paddr[11:4] == craf_pkg::MSK_SID_BASE[11:4] && mIdx != 2'h3)
    begin
      rdata[15:0] = mskSid[mIdx] & craf_pkg::SID_REG_WMASK;
    end else if (paddr[11:4] == craf_pkg::MSK_EID_BASE[11:4] && mIdx != 2'h3)
    begin
      rdata[15:0] = mskEid[mIdx];
    end else begin
      case (paddr)
        craf_pkg::SEL_LOW_OFS: rdata[15:0] = selLow;
        craf_pkg::SEL_HIGH_OFS: rdata[15:0] = selHigh;
        craf_pkg::FULL_LOW_OFS: rdata[15:0] = fullFlag[15:0];
        craf_pkg::FULL_HIGH_OFS: rdata[15:0] = fullFlag[31:16];
        craf_pkg::OVF_LOW_OFS: rdata[15:0] = ovfFlag[15:0];
        craf_pkg::OVF_HIGH_OFS: rdata[15:0] = ovfFlag[31:16];
        craf_pkg::INT_STAT_OFS: rdata[1:0] = intStat;
        craf_pkg::INT_CLR_OFS: rdata = 32'h0000_0000;
        craf_pkg::INT_EN_OFS: rdata[1:0] = intEn;
        default: rdErr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identifier registers carry no reset; software must load them first
  always_ff @(posedge clk) begin
    if (apbWr && !rdErr) begin
      if (paddr[11:6] == craf_pkg::FLT_EID_BASE[11:6]) begin
        fltEid[fIdx] <= wd;
      end
      if (paddr[11:6] == craf_pkg::FLT_SID_BASE[11:6]) begin
        fltSid[fIdx] <= wd & craf_pkg::SID_REG_WMASK;
      end
      if (paddr[11:4] == craf_pkg::MSK_SID_BASE[11:4]) begin
        mskSid[mIdx] <= wd & craf_pkg::SID_REG_WMASK;
      end
      if (paddr[11:4] == craf_pkg::MSK_EID_BASE[11:4]) begin
        mskEid[mIdx] <= wd;
      end
    end
  end // R12

  // Mask selectors and interrupt enables reset to zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      selLow <= craf_pkg::SEL_RESET; // R12
      selHigh <= craf_pkg::SEL_RESET; // R12
      intEn <= craf_pkg::INT_RESET;
    end else if (apbWr) begin
      if (paddr == craf_pkg::SEL_LOW_OFS) selLow <= wd;
      if (paddr == craf_pkg::SEL_HIGH_OFS) selHigh <= wd;
      if (paddr == craf_pkg::INT_EN_OFS) intEn <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-filter comparison against the mask that its selector names
  for (genvar f = 0; f < craf_pkg::NUM_FILTERS; f++) begin : gFilter
    logic [1:0] sel;
    logic [15:0] mSid;
    logic [15:0] mEid;
    logic selOk;
    logic [17:0] eidCmp;
    logic [17:0] eidInc;
    logic stdEq;
    logic extEq;
    logic filter_ext_frame_enable;

    // Filters 0..7 in the low register, 8..15 in the high one
    if (f < 8) begin : gLo
      assign sel = selLow[2*f +: 2]; // R03
    end else begin : gHi
      assign sel = selHigh[2*(f-8) +: 2]; // R04
    end

    // Reserved code selects nothing, so the filter never hits
    always_comb begin
      mSid = mskSid[0];
      mEid = mskEid[0];
      selOk = 1'b1;
      case (craf_pkg::craf_sel_e'(sel))
        craf_pkg::SEL_MASK0: begin
          mSid = mskSid[0];
          mEid = mskEid[0];
        end
        craf_pkg::SEL_MASK1: begin
          mSid = mskSid[1];
          mEid = mskEid[1];
        end
        craf_pkg::SEL_MASK2: begin
          mSid = mskSid[2];
          mEid = mskEid[2];
        end
        default: selOk = 1'b0;
      endcase
    end // R02

    assign filter_ext_frame_enable = fltSid[f][craf_pkg::TYPE_BIT];
    assign eidCmp = {fltSid[f][craf_pkg::EIDHI_LSB +: 2], fltEid[f]};
    assign eidInc = {mSid[craf_pkg::EIDHI_LSB +: 2], mEid}; // R06
    // Only included bits may break a match
    assign stdEq = ~|((rxFrame.std_ident_bits ^ fltSid[f][craf_pkg::SID_LSB +: 11])
                      & mSid[craf_pkg::SID_LSB +: 11]); // R05
    assign extEq = stdEq && ~|((rxFrame.ext_ident_bits ^ eidCmp) & eidInc); // R01
    assign hitVec[f] = selOk && (mSid[craf_pkg::TYPE_BIT]
      ? (rxFrame.ext == filter_ext_frame_enable) && (filter_ext_frame_enable ? extEq : stdEq) // R07
      : (stdEq || extEq)); // R08 R14
  end

  // Lowest numbered filter wins when several hit
  always_comb begin
    anyHit = 1'b0;
    hitNum = 5'h00;
    for (int i = craf_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        anyHit = 1'b1;
        hitNum = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer flags: hardware set beats a same-cycle software clear
  always_comb begin
    setFull = 32'h0000_0000;
    setOvf = 32'h0000_0000;
    if (rxFrame.valid && anyHit) begin
      if (fullFlag[rxFrame.bufIdx]) begin
        setOvf[rxFrame.bufIdx] = 1'b1; // R13
      end else begin
        setFull[rxFrame.bufIdx] = 1'b1; // R09 R11
      end
    end
    next_fullFlag = fullFlag;
    next_ovfFlag = ovfFlag;
    if (apbWr) begin
      case (paddr)
        craf_pkg::FULL_LOW_OFS: next_fullFlag[15:0] = fullFlag[15:0] & wd;
        craf_pkg::FULL_HIGH_OFS: next_fullFlag[31:16] = fullFlag[31:16] & wd;
        craf_pkg::OVF_LOW_OFS: next_ovfFlag[15:0] = ovfFlag[15:0] & wd;
        craf_pkg::OVF_HIGH_OFS: next_ovfFlag[31:16] = ovfFlag[31:16] & wd;
        default: ;
      endcase
    end // R10
    next_fullFlag = next_fullFlag | setFull;
    next_ovfFlag = next_ovfFlag | setOvf;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fullFlag <= {2{craf_pkg::FLAG_RESET}}; // R10
      ovfFlag <= {2{craf_pkg::FLAG_RESET}}; // R10
    end else begin
      fullFlag <= next_fullFlag;
      ovfFlag <= next_ovfFlag;
    end
  end

  // Store request to buffer RAM; an overrun frame is dropped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      store <= '0;
    end else begin
      store.valid <= |setFull;
      store.bufIdx <= rxFrame.bufIdx;
      store.filterNum <= hitNum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write one to clear, set wins
  always_comb begin
    next_intStat = intStat;
    if (apbWr && paddr == craf_pkg::INT_CLR_OFS) begin
      next_intStat = intStat & ~pwdata[1:0];
    end
    next_intStat[craf_pkg::INT_ACCEPT] = next_intStat[craf_pkg::INT_ACCEPT]
                                         | (|setFull);
    next_intStat[craf_pkg::INT_OVERRUN] = next_intStat[craf_pkg::INT_OVERRUN]
                                          | (|setOvf);
  end

  // Output registered, so it trails the status by one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      intStat <= craf_pkg::INT_RESET;
      irq <= 1'b0;
    end else begin
      intStat <= next_intStat;
      irq <= |(intStat & intEn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_full_set: assert property (@(posedge clk) disable iff (!rst_b) // R09
    rxFrame.valid && anyHit && !fullFlag[rxFrame.bufIdx]
    |=> fullFlag[$past(rxFrame.bufIdx)] && store.valid)
    else $error("occupied flag not set on accepted frame");

  a_ovf_drop: assert property (@(posedge clk) disable iff (!rst_b) // R13
    rxFrame.valid && anyHit && fullFlag[rxFrame.bufIdx]
    |=> ovfFlag[$past(rxFrame.bufIdx)] && !store.valid)
    else $error("overrun not flagged or frame stored");

  a_high_half: assert property (@(posedge clk) disable iff (!rst_b) // R11
    store.valid && store.bufIdx[4] |-> fullFlag[31:16] != 16'h0000)
    else $error("upper buffer flag missing");

  // Bits written with one keep their old value, plus any same-cycle set
  a_one_keeps: assert property (@(posedge clk) disable iff (!rst_b) // R10
    apbWr && paddr == craf_pkg::FULL_LOW_OFS
    |=> ((fullFlag[15:0] ^ ($past(fullFlag[15:0]) | $past(setFull[15:0])))
        & $past(wd)) == 16'h0000)
    else $error("writing one changed an occupied flag");

  a_zero_clears: assert property (@(posedge clk) disable iff (!rst_b) // R10
    apbWr && paddr == craf_pkg::OVF_LOW_OFS && wd == 16'h0000
    && !(|setOvf[15:0]) |=> ovfFlag[15:0] == 16'h0000)
    else $error("writing zero left an overrun flag");

  a_sel_reset: assert property (@(posedge clk) // R12
    !rst_b |=> selLow == 16'h0000 && selHigh == 16'h0000)
    else $error("selectors not zero after reset");

  a_rsvd_nohit: assert property (@(posedge clk) disable iff (!rst_b) // R02
    selLow[1:0] == 2'h3 |-> !hitVec[0])
    else $error("reserved selector produced a hit");

  a_type_mode: assert property (@(posedge clk) disable iff (!rst_b) // R07
    selLow[1:0] == 2'h0 && mskSid[0][craf_pkg::TYPE_BIT]
    && rxFrame.ext != fltSid[0][craf_pkg::TYPE_BIT] |-> !hitVec[0])
    else $error("frame format mismatch accepted");

  a_eid_miss: assert property (@(posedge clk) disable iff (!rst_b) // R01
    selLow[1:0] == 2'h0 && mskSid[0][craf_pkg::TYPE_BIT]
    && fltSid[0][craf_pkg::TYPE_BIT]
    && ((rxFrame.ext_ident_bits[15:0] ^ fltEid[0]) & mskEid[0]) != 16'h0000
    |-> !hitVec[0])
    else $error("extended identifier mismatch accepted");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 irq == |($past(intStat) & $past(intEn)))
    else $error("interrupt output wrong");

  a_apb_wait: assert property (@(posedge clk) disable iff (!rst_b)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("slave answer not one wait state");

  // A frame that no filter takes leaves the buffer RAM alone
  a_miss_quiet: assert property (@(posedge clk) disable iff (!rst_b) // R14
    rxFrame.valid && !anyHit |=> !store.valid)
    else $error("store issued for a rejected frame");

  // Type mode clear: a standard identifier match alone is enough
  a_mode_any: assert property (@(posedge clk) disable iff (!rst_b) // R08
    selLow[5:4] == 2'h1 && !mskSid[1][craf_pkg::TYPE_BIT]
    && ((rxFrame.std_ident_bits ^ fltSid[2][craf_pkg::SID_LSB +: 11])
        & mskSid[1][craf_pkg::SID_LSB +: 11]) == 11'h000
    |-> hitVec[2])
    else $error("standard identifier match refused in either-format mode");

  // Overrun bits rise only on a hit aimed at an occupied buffer
  a_ovf_cause: assert property (@(posedge clk) disable iff (!rst_b) // R13
    !(rxFrame.valid && anyHit) |=> (ovfFlag & ~$past(ovfFlag)) == 32'h0)
    else $error("overrun flag set without a frame");

  c_accept: cover property (@(posedge clk) disable iff (!rst_b)
    store.valid);
  c_overrun: cover property (@(posedge clk) disable iff (!rst_b)
    |setOvf);
  c_clear_race: cover property (@(posedge clk) disable iff (!rst_b)
    apbWr && paddr == craf_pkg::FULL_LOW_OFS && |setFull[15:0]);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);

endmodule // craf_acceptance_filter

// ---- tb/craf_frame_src.sv ----
// Frame source model standing in for the CAN protocol engine
`timescale 1ns/1ps
module craf_frame_src (
  input wire logic clk,
  output craf_pkg::craf_frame_s rxFrame
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle fields show the inverse of the last frame so stale data never helps
  initial rxFrame = '0;

  // One-cycle valid pulse, launched just after a rising edge
  task automatic send(input logic ext, input logic [10:0] std_ident_bits,
                      input logic [17:0] ext_ident_bits, input logic [4:0] bufIdx);
    craf_pkg::craf_frame_s f;
    f = {1'b1, ext, std_ident_bits, ext_ident_bits, bufIdx};
    @(posedge clk);
    rxFrame <= f;
    @(posedge clk);
    rxFrame <= {1'b0, ~f[34:0]};
  endtask
endmodule // craf_frame_src

// ---- tb/can_rx_acceptance_filter_test.sv ----
// Self-checking bench for the receive acceptance filter
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_fail++; $display("ERROR %0t: got %h expected %h", $time, got, exp); \
  end end
module can_rx_acceptance_filter_test;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] rnd = 32'h29c8;
  craf_pkg::craf_frame_s rxFrame;
  craf_pkg::craf_store_s store;
  int n_fail = 0;
  int checks_done = 0;
  logic [32:0] expRd[$];
  logic [9:0] expSt[$];
  logic [32:0] eRd;
  logic [9:0] eSt;

  craf_acceptance_filter u_craf_acceptance_filter (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxFrame(rxFrame), .store(store), .irq(irq));
  craf_frame_src u_craf_frame_src (.clk(clk), .rxFrame(rxFrame));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Each result is paired with the oldest note as it appears
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expRd.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        // Pop once: the macro may evaluate its argument twice
        eRd = expRd.pop_front();
        `CHK({pslverr, prdata}, eRd)
      end
    end
    if (store.valid !== 1'b0) begin
      if (expSt.size() == 0) `CHK(store.valid, 1'b0)
      else begin
        eSt = expSt.pop_front();
        `CHK({store.bufIdx, store.filterNum}, eSt)
      end
    end
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Linear feedback shift register step
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Identifier register image: id, type bit, top two extended bits
  function automatic logic [15:0] sidReg(input logic [10:0] s,
                                         input logic t, input logic [1:0] h);
    return {s, 1'b0, t, 1'b0, h};
  endfunction

  // One APB transfer; holds the request until pready is sampled high
  // Only the watchdog ends a wait that never sees pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask

  // Read with the expected word and error noted first
  task automatic rd(input logic [11:0] a, input logic [15:0] d,
                    input logic e);
    expRd.push_back({e, 16'h0, d});
    apb(1'b0, a, 32'h0);
  endtask

  // Frame with the expected store noted first when it should hit
  task automatic frame(input logic ext, input logic [10:0] std_ident_bits,
                       input logic [17:0] ext_ident_bits, input logic [4:0] b,
                       input logic hit, input logic [4:0] f);
    if (hit) expSt.push_back({b, f});
    u_craf_frame_src.send(ext, std_ident_bits, ext_ident_bits, b);
    repeat (2) @(posedge clk);
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(craf_pkg::SEL_LOW_OFS, craf_pkg::SEL_RESET, 1'b0);
    rd(craf_pkg::SEL_HIGH_OFS, craf_pkg::SEL_RESET, 1'b0);
    for (int a = 0; a < 5; a++)
      rd(craf_pkg::FULL_LOW_OFS + 12'(4 * a), 16'h0, 1'b0);
    rd(12'hffc, 16'h0, 1'b1);
    rd(12'h0a2, 16'h0, 1'b1);
    $display("test reset done");
    // Unique identifiers per filter; mask 0 exact, 1 id only, 2 loose
    for (int n = 0; n < 16; n++) begin
      wr(craf_pkg::FLT_SID_BASE + 12'(4 * n),
         sidReg(11'h100 + 11'(n), 1'b1, 2'h0));
      wr(craf_pkg::FLT_EID_BASE + 12'(4 * n), 16'h1000 + 16'(n));
    end
    wr(craf_pkg::MSK_SID_BASE, sidReg(11'h7ff, 1'b1, 2'h3));
    wr(craf_pkg::MSK_EID_BASE, 16'hffff);
    wr(craf_pkg::MSK_SID_BASE + 12'h4, sidReg(11'h7ff, 1'b0, 2'h0));
    wr(craf_pkg::MSK_EID_BASE + 12'h4, 16'h0);
    wr(craf_pkg::MSK_SID_BASE + 12'h8, sidReg(11'h7f0, 1'b1, 2'h3));
    wr(craf_pkg::MSK_EID_BASE + 12'h8, 16'hffff);
    rd(craf_pkg::MSK_SID_BASE + 12'h8, sidReg(11'h7f0, 1'b1, 2'h3), 1'b0);
    wr(craf_pkg::INT_EN_OFS, 16'h0001);
    for (int f = 0; f < 16; f++)
      frame(1'b1, 11'h100 + 11'(f), {2'h0, 16'h1000 + 16'(f)},
            5'(f), 1'b1, 5'(f));
    rd(craf_pkg::FULL_LOW_OFS, 16'hffff, 1'b0);
    `CHK(irq, 1'b1)
    $display("test filter hits done");
    frame(1'b1, 11'h103, {2'h0, 16'h1003}, 5'd3, 1'b0, 5'd0);
    rd(craf_pkg::OVF_LOW_OFS, 16'h0008, 1'b0);
    wr(craf_pkg::FULL_LOW_OFS, 16'h00ff);
    rd(craf_pkg::FULL_LOW_OFS, 16'h00ff, 1'b0);
    wr(craf_pkg::OVF_LOW_OFS, 16'h0000);
    rd(craf_pkg::OVF_LOW_OFS, 16'h0000, 1'b0);
    rd(craf_pkg::INT_STAT_OFS, 16'h0003, 1'b0);
    wr(craf_pkg::INT_CLR_OFS, 16'h0001);
    rd(craf_pkg::INT_STAT_OFS, 16'h0002, 1'b0);
    `CHK(irq, 1'b0)
    wr(craf_pkg::INT_EN_OFS, 16'h0002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(craf_pkg::INT_CLR_OFS, 16'h0002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test flags and interrupt done");
    frame(1'b1, 11'h100, {2'h0, 16'h1020}, 5'd20, 1'b0, 5'd0);
    frame(1'b0, 11'h100, 18'h0, 5'd20, 1'b0, 5'd0);
    frame(1'b1, 11'h100, {2'h1, 16'h1000}, 5'd20, 1'b0, 5'd0);
    $display("test rejects done");
    // Filter 2 to mask 1, filter 15 to mask 2
    wr(craf_pkg::SEL_LOW_OFS, 16'h0010);
    rnd = lfsr(rnd);
    frame(1'b0, 11'h102, rnd[17:0], 5'd16, 1'b1, 5'd2);
    rnd = lfsr(rnd);
    frame(1'b1, 11'h102, rnd[17:0], 5'd17, 1'b1, 5'd2);
    wr(craf_pkg::SEL_HIGH_OFS, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      frame(1'b1, 11'h100 | 11'(rnd[3:0] & 4'hd), {2'h0, 16'h100f},
            5'd24 + 5'(i), 1'b1, 5'd15);
    end
    rd(craf_pkg::FULL_HIGH_OFS, 16'h0f03, 1'b0);
    // Reserved selector code on filter 0 must not hit
    wr(craf_pkg::SEL_LOW_OFS, 16'h0013);
    frame(1'b1, 11'h100, {2'h0, 16'h1000}, 5'd21, 1'b0, 5'd0);
    rd(craf_pkg::SEL_LOW_OFS, 16'h0013, 1'b0);
    $display("test mask select done");
    repeat (4) @(posedge clk);
    if (expRd.size() != 0 || expSt.size() != 0) begin
      n_fail++;
      $display("ERROR %0t: expected results never appeared", $time);
    end
    conclude();
  end
endmodule // can_rx_acceptance_filter_test
